/* src/sac_pkg.sv */
package sac_pkg;

  // Clock rate and printed times.
  localparam int CLK_NS = 40;
  localparam int STS_RISE_NS = 200;
  localparam int STS_TAIL_NS = 1000;
  localparam int DATA_LEAD_NS = 600;
  // Cycle counts: least times round up.
  localparam int STS_RISE_CYC = (STS_RISE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STS_TAIL_CYC = (STS_TAIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_LEAD_CYC = (DATA_LEAD_NS + CLK_NS - 1) / CLK_NS;

  // Conversion lengths and bit-step divider.
  localparam int FULL_BITS = 12;
  localparam int SHORT_BITS = 8;
  localparam int STEP_DIV = 16;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  // Controller states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b000,
    SAC_START = 3'b001,
    SAC_CONV = 3'b011,
    SAC_ACQ = 3'b010
  } sac_state_t;

endpackage : sac_pkg

/* src/sac_sar.sv */
`timescale 1ns/1ns
`default_nettype none
module sac_sar
  import sac_pkg::*;
#(
  parameter int WIDTH = 12
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clear_in,
  input wire logic step_in,
  input wire logic short_in,
  input wire logic comp_below_in,
  output logic [WIDTH-1:0] trial_out,
  output logic done_out
);

  initial begin
    if (WIDTH < SHORT_BITS) $error("WIDTH too small");
  end

  typedef struct packed {
    logic [WIDTH-1:0] result;
    logic [WIDTH-1:0] mask;
    logic done;
  } sac_sar_t;

  sac_sar_t r;
  sac_sar_t next_r;

  // One bit trial per step, MSB first; the bit stays set when the sum was below the input.
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (clear_in) begin
      next_r.result = {1'b1, {(WIDTH-1){1'b0}}};
      next_r.mask = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step_in && (r.mask != '0)) begin
      if (!comp_below_in) begin
        next_r.result = r.result & ~r.mask;
      end
      next_r.mask = r.mask >> 1;
      if (short_in && r.mask[WIDTH-SHORT_BITS]) begin
        next_r.mask = '0;
      end
      next_r.result = next_r.result | (next_r.mask >> 0);
      if ((next_r.mask == '0) || (short_in && r.mask[WIDTH-SHORT_BITS])) begin
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign trial_out = r.result;
  assign done_out = r.done;

endmodule : sac_sar
`default_nettype wire

/* src/sac_control.sv */
`timescale 1ns/1ns
`default_nettype none
module sac_control
  import sac_pkg::*;
#(
  parameter int WIDTH = 12,
  parameter int STEP_CYCLES = STEP_DIV
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic chip_enable_in,
  input wire logic chip_select_n_in,
  input wire logic read_convert_in,
  input wire logic word_format_in,
  input wire logic byte_select_in,
  input wire logic comp_below_in,
  output logic [WIDTH-1:0] dac_trial_out,
  output logic [WIDTH-1:0] data_out,
  output logic [WIDTH-1:0] data_oe_out,
  output logic conversion_status_out,
  output logic hold_out,
  output logic conv_clk_en_out
);

  initial begin
    if (WIDTH != FULL_BITS) $error("WIDTH must be 12");
    if (STEP_CYCLES < 2) $error("STEP_CYCLES too small");
    if (STS_TAIL_CYC <= DATA_LEAD_CYC) $error("tail shorter than data lead");
  end

  typedef struct packed {
    logic [1:0] ce_s;
    logic [1:0] cs_n_s;
    logic [1:0] rc_s;
    logic [1:0] wf_s;
    logic [1:0] bs_s;
    logic [1:0] cmp_s;
    logic sel_prev;
    sac_state_t state;
    logic short_conv;
    logic [7:0] cnt;
    logic [7:0] step_cnt;
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] data;
    logic [WIDTH-1:0] oe;
    logic sts;
    logic hold;
    logic clk_en;
  } sac_ctl_t;

  sac_ctl_t r;
  sac_ctl_t next_r;
  logic sar_clear;
  logic sar_step;
  logic [WIDTH-1:0] sar_trial;
  logic sar_done;

  // Output word for a read; byte mode puts the low nibble in the upper half.
  function automatic logic [WIDTH-1:0] read_word(input logic [WIDTH-1:0] res, input logic wf, input logic bs);
    logic [WIDTH-1:0] w;
    w = '0;
    if (wf) begin
      w = res;
    end else if (!bs) begin
      w[7:0] = res[11:4];
    end else begin
      w[7:0] = {res[3:0], 4'h0};
    end
    return w;
  endfunction : read_word

  // Which lanes a read enables.
  function automatic logic [WIDTH-1:0] read_lanes(input logic wf);
    return wf ? {WIDTH{1'b1}} : {{(WIDTH-8){1'b0}}, 8'hff};
  endfunction : read_lanes

  logic selected;
  logic rc_now;
  assign selected = r.ce_s[1] && !r.cs_n_s[1];
  assign rc_now = r.rc_s[1];

  // The successive approximation register lives in its own module.
  sac_sar #(
    .WIDTH(WIDTH)
  ) u_sar (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clear_in(sar_clear),
    .step_in(sar_step),
    .short_in(r.short_conv),
    .comp_below_in(r.cmp_s[1]),
    .trial_out(sar_trial),
    .done_out(sar_done)
  );

  assign sar_clear = (r.state == SAC_START) && (r.cnt == 8'h00);
  assign sar_step = (r.state == SAC_CONV) && r.clk_en && (r.step_cnt == 8'(STEP_CYCLES - 1));

  // Controller: start decode, conversion sequencing, acquisition tail and reads.
  always_comb begin
    next_r = r;
    // Pins are foreign to this clock, so each gets two flops first.
    next_r.ce_s = {r.ce_s[0], chip_enable_in};
    next_r.cs_n_s = {r.cs_n_s[0], chip_select_n_in};
    next_r.rc_s = {r.rc_s[0], read_convert_in};
    next_r.wf_s = {r.wf_s[0], word_format_in};
    next_r.bs_s = {r.bs_s[0], byte_select_in};
    next_r.cmp_s = {r.cmp_s[0], comp_below_in};
    next_r.sel_prev = selected;
    next_r.data = '0;
    next_r.oe = '0;
    if (r.state == SAC_CONV) begin
      next_r.step_cnt = (r.step_cnt == 8'(STEP_CYCLES - 1)) ? 8'h00 : r.step_cnt + 8'h01;
    end
    case (r.state)
      SAC_IDLE: begin
        if (selected && !rc_now) begin
          // Whichever of enable and select comes last triggers; a low read/convert
          // under an existing selection (stand-alone) also starts.
          next_r.state = SAC_START;
          next_r.short_conv = r.bs_s[1];
          next_r.hold = 1'b1;
          next_r.cnt = 8'h00;
        end else if (selected && rc_now) begin
          next_r.data = read_word(r.latch, r.wf_s[1], r.bs_s[1]);
          next_r.oe = read_lanes(r.wf_s[1]);
        end
      end
      SAC_START: begin
        // Data float from the start edge on.
        next_r.clk_en = 1'b1;
        next_r.step_cnt = 8'h00;
        next_r.cnt = r.cnt + 8'h01;
        if (r.cnt == 8'(STS_RISE_CYC - 1)) begin
          next_r.sts = 1'b1;
          next_r.state = SAC_CONV;
        end
      end
      SAC_CONV: begin
        // Starts and reads are not looked at here, so nothing can disturb the cycle.
        if (sar_done) begin
          next_r.clk_en = 1'b0;
          next_r.hold = 1'b0;
          next_r.latch = sar_trial;
          next_r.cnt = 8'h00;
          next_r.state = SAC_ACQ;
        end
      end
      SAC_ACQ: begin
        // Data valid from here; status falls a fixed tail later, well after the lead.
        next_r.cnt = r.cnt + 8'h01;
        if (selected && rc_now) begin
          next_r.data = read_word(r.latch, r.wf_s[1], r.bs_s[1]);
          next_r.oe = read_lanes(r.wf_s[1]);
        end
        if (r.cnt == 8'(STS_TAIL_CYC - 1)) begin
          next_r.sts = 1'b0;
          next_r.state = SAC_IDLE;
        end
      end
      default: begin
        next_r.state = SAC_IDLE;
      end
    endcase
  end

  // All state updates on one clock; reset gives idle, sample mode, floating bus.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.cs_n_s <= 2'b11;
      r.latch <= RESULT_RESET;
      r.state <= SAC_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign dac_trial_out = sar_trial;
  assign data_out = r.data;
  assign data_oe_out = r.oe;
  assign conversion_status_out = r.sts;
  assign hold_out = r.hold;
  assign conv_clk_en_out = r.clk_en;

  // No data during a conversion.
  a_no_data_conv: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_CONV) |-> (data_oe_out == '0))
    else $error("data driven in conversion");

  // Start holds the track-hold.
  a_start_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_START) |-> hold_out)
    else $error("no hold at start");

  // Status rises the fixed delay after start.
  a_sts_rise: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($rose(hold_out)) |-> ##5 $rose(conversion_status_out))
    else $error("status rise late");

  // End of convert stops the clock and samples.
  a_eoc_stop: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($fell(conv_clk_en_out)) |-> (!hold_out && conversion_status_out))
    else $error("eoc wrong");

  // Status stays high for at least eight cycles after sampling resumes.
  a_sts_tail: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ($fell(hold_out)) |-> conversion_status_out [*8])
    else $error("status tail short");

  // Conversion stays in conversion or moves on to acquisition, regardless of inputs.
  a_conv_keep: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_CONV) |=> (r.state == SAC_CONV) || (r.state == SAC_ACQ))
    else $error("abort");

  // Status only drops from acquisition.
  a_sts_fall: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(conversion_status_out) |-> $past(r.state) == SAC_ACQ)
    else $error("status fell early");

  // Byte read keeps the upper lanes quiet.
  a_byte_zeros: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (data_oe_out == 12'h0ff) |-> (data_out[11:8] == 4'h0))
    else $error("byte lanes wrong");

  // Word read returns the held result.
  a_word_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (data_oe_out == 12'hfff) |-> (data_out == r.latch))
    else $error("word read wrong");

  // A start needs the selection to have stood in the cycle that took it.
  a_start_gated: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(hold_out) |-> r.sel_prev)
    else $error("start without selection");

  // A start is only taken with read/convert low; a high level is a read.
  a_start_convert: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(hold_out) |-> !$past(rc_now))
    else $error("start during read");

  // Conversion length follows the byte select seen at the start.
  a_start_length: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(hold_out) |-> (r.short_conv == $past(r.bs_s[1])))
    else $error("wrong conversion length");

  // A short run never trials the four low bits.
  a_short_tail: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((r.state == SAC_CONV) && sar_done && r.short_conv) |-> (sar_trial[3:0] == 4'h0))
    else $error("short run set low bits");

  // Right after the clear only the first trial bit stands and the step clock runs.
  a_clear_first: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((r.state == SAC_START) && (r.cnt == 8'h01)) |-> (conv_clk_en_out && (dac_trial_out == {1'b1, {(WIDTH-1){1'b0}}})))
    else $error("register not cleared");

  // Outside a run the step clock is stopped and the track-hold samples.
  a_sample_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((r.state == SAC_IDLE) || (r.state == SAC_ACQ)) |-> (!conv_clk_en_out && !hold_out))
    else $error("clock or hold left on");

  // A read during the acquisition tail is served on the next cycle.
  a_acq_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((r.state == SAC_ACQ) && selected && rc_now) |=> (data_oe_out != '0))
    else $error("acquisition read refused");

  // The lines float from the start edge on, before the first trial.
  a_start_float: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_START) |-> (data_oe_out == '0))
    else $error("data driven at start");

  // Status stays high while bits are trialled.
  a_sts_conv: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_CONV) |-> conversion_status_out)
    else $error("status low in conversion");

  // Status is low whenever the controller is idle.
  a_sts_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_IDLE) |-> !conversion_status_out)
    else $error("status high in idle");

  // The odd byte carries the low nibble followed by zeros.
  a_byte_high: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((data_oe_out == 12'h0ff) && $past(r.bs_s[1])) |-> (data_out[3:0] == 4'h0))
    else $error("odd byte wrong");

  // The even byte carries the eight top result bits.
  a_byte_low: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    ((data_oe_out == 12'h0ff) && !$past(r.bs_s[1])) |-> (data_out[7:0] == r.latch[11:4]))
    else $error("even byte wrong");

  // The result is only replaced when a run completes, so reads repeat.
  a_latch_keep: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state != SAC_CONV) |=> $stable(r.latch))
    else $error("result changed");

  // Reads open with the acquisition tail, so at least the data lead passes before status falls.
  a_data_lead: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $fell(conversion_status_out) |-> ($past(r.state, 15) == SAC_ACQ))
    else $error("data lead too short");

  // Word format picks all lanes; byte format only the low eight.
  a_word_lanes: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (data_oe_out != '0) |-> (data_oe_out == ($past(r.wf_s[1]) ? 12'hfff : 12'h0ff)))
    else $error("lane enables wrong");

  // The track-hold stays in hold for the whole run.
  a_hold_conv: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    (r.state == SAC_CONV) |-> hold_out)
    else $error("hold released in conversion");

  // Status only rises once the input is held.
  a_sts_start: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(conversion_status_out) |-> hold_out)
    else $error("status without hold");

  // Main scenarios: any completed run, short run, acquisition read, byte read and a start straight after a run.
  c_conv: cover property (@(posedge clock_in) $fell(conversion_status_out));
  c_short: cover property (@(posedge clock_in) r.short_conv && $fell(conv_clk_en_out));
  c_acq_read: cover property (@(posedge clock_in) (r.state == SAC_ACQ) && (data_oe_out != '0));
  c_byte_read: cover property (@(posedge clock_in) data_oe_out == 12'h0ff);
  c_restart: cover property (@(posedge clock_in) $fell(conversion_status_out) ##1 $rose(hold_out));

endmodule : sac_control
`default_nettype wire

/* dv/sac_comp_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sac_comp_model (
  input wire logic [11:0] trial_in,
  input wire logic [11:0] level_in,
  output logic below_out
);
  // A tie counts as below, so the result lands on the level itself.
  assign below_out = (trial_in <= level_in);
endmodule : sac_comp_model
`default_nettype wire

/* dv/sar_adc_bus_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module sar_adc_bus_control_tb;
  import sac_pkg::*;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ce = 1'b0, sel_n = 1'b1, rc = 1'b1, wf = 1'b1, bs = 1'b0, below;
  logic [11:0] level = 12'h000, trial, data, oe;
  logic sts, hold, clk_en;
  int failures = 0;
  int n_tests = 0;

  sac_control dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .chip_enable_in(ce),
    .chip_select_n_in(sel_n), .read_convert_in(rc), .word_format_in(wf), .byte_select_in(bs),
    .comp_below_in(below), .dac_trial_out(trial), .data_out(data), .data_oe_out(oe),
    .conversion_status_out(sts), .hold_out(hold), .conv_clk_en_out(clk_en));
  sac_comp_model comp (.trial_in(trial), .level_in(level), .below_out(below));

  // Free-running clock.
  initial begin
    forever #20 clock_in = ~clock_in;
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pin order: enable, select_n, read_convert, word_format, byte_select; set at a falling edge.
  task automatic pins(input logic [4:0] p);
    {ce, sel_n, rc, wf, bs} = p;
  endtask : pins

  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask : idle

  // Bounded wait: 0 hold, 1 status, 2 any output enable.
  task automatic wait_for(input int s, input logic v, output int n);
    n = 0;
    while (((s == 0) ? hold : (s == 1) ? sts : |oe) !== v) begin
      idle(1);
      n++;
      if (n > 400) begin
        check(12'(s), 12'hfff);
        give_verdict();
      end
    end
  endtask : wait_for

  // Full-control conversion with a refused restart and a refused read in mid-run.
  task automatic convert(input logic [11:0] lvl, input logic sh);
    int n;
    level = lvl;
    // Read/convert is low before both are asserted; enable comes last on a full run, select on a short one.
    pins({sh ? 4'b1101 : 4'b0001, sh});
    idle(2);
    pins({4'b1001, sh});
    wait_for(0, 1'b1, n);
    pins({4'b0101, sh});
    wait_for(1, 1'b1, n);
    check(12'(n), 12'(STS_RISE_CYC));
    check(12'(clk_en), 12'h001);
    pins({4'b1001, ~sh});
    idle(20);
    pins(5'b10110);
    idle(5);
    check(oe, 12'h000);
    check(12'(hold), 12'h001);
    pins(5'b01110);
    wait_for(0, 1'b0, n);
    check(12'({clk_en, sts}), 12'h001);
    pins(5'b10110);
    idle(4);
    check(oe, 12'hfff);
    check(data, sh ? {lvl[11:4], 4'h0} : lvl);
    wait_for(1, 1'b0, n);
    check(12'(n + 4), 12'(STS_TAIL_CYC));
    pins(5'b01110);
    idle(4);
  endtask : convert

  // Byte reads in idle, then a repeated word read of the held result.
  task automatic read_bytes(input logic [11:0] res);
    pins(5'b10100);
    idle(4);
    check(oe, 12'h0ff);
    check(data, {4'h0, res[11:4]});
    pins(5'b10101);
    idle(4);
    check(data, {4'h0, res[3:0], 4'h0});
    pins(5'b10111);
    idle(4);
    check(data, res);
    pins(5'b01110);
    idle(4);
  endtask : read_bytes

  // Without both enable and select nothing converts or drives.
  task automatic gating();
    logic [2:0] tbl [4] = '{3'b000, 3'b110, 3'b001, 3'b111};
    foreach (tbl[i]) begin
      pins({tbl[i], 2'b10});
      idle(20);
      check({oe[10:0], hold}, 12'h000);
    end
    pins(5'b01110);
    idle(2);
  endtask : gating

  // Stand-alone low pulse on read_convert.
  task automatic standalone(input logic [11:0] lvl, input logic [11:0] prev);
    int n;
    level = lvl;
    pins(5'b10110);
    idle(4);
    check(oe, 12'hfff);
    check(data, prev);
    pins(5'b10010);
    wait_for(1, 1'b1, n);
    check(oe, 12'h000);
    check(12'(n >= STS_RISE_CYC), 12'h001);
    pins(5'b10110);
    wait_for(2, 1'b1, n);
    check(12'(sts), 12'h001);
    wait_for(1, 1'b0, n);
    check(12'(n >= DATA_LEAD_CYC), 12'h001);
    check(data, lvl);
    pins(5'b10010);
    idle(8);
    check(oe, 12'h000);
    pins(5'b10110);
    wait_for(1, 1'b0, n);
  endtask : standalone

  // Main sequence.
  initial begin
    idle(8);
    sys_rst_in = 1'b0;
    check({oe[9:0], sts, hold}, 12'h000);
    gating();
    convert(12'ha5c, 1'b0);
    read_bytes(12'ha5c);
    convert(12'h3c7, 1'b1);
    read_bytes(12'h3c0);
    standalone(12'h5a3, 12'h3c0);
    give_verdict();
  end
endmodule : sar_adc_bus_control_tb
`default_nettype wire
